//--- logic/sbo_pkg.sv
`default_nettype none

package sbo_pkg;

  // ***************************************************
  // Instruction field layout
  // ***************************************************
  localparam int SUB_MSB    = 10;
  localparam int SUB_LSB    = 7;
  localparam int BIDX_MSB   = 6;
  localparam int BIDX_LSB   = 3;
  localparam int RSEL_MSB   = 2;
  localparam int RSEL_LSB   = 0;

  // ***************************************************
  // Status word
  // ***************************************************
  localparam logic [2:0]  PSW_SELECT      = 3'h0;
  localparam logic [3:0]  PSW_OFFSET      = 4'h1;
  localparam logic [15:0] PSW_RESET       = 16'h0000;
  localparam logic [15:0] PSW_WRITE_MASK  = 16'h00ff;
  localparam int          PTM_BIT         = 0;
  localparam int          ROUND_BIT       = 1;
  localparam int          ACCUM_BIT       = 2;
  localparam int          ERROR_BIT       = 3;
  localparam int          DYN_OVF_BIT     = 4;
  localparam int          STAT_OVF_BIT    = 5;
  localparam int          CARRY_BIT       = 6;
  localparam int          MSHIFT_BIT      = 7;
  localparam int          LEVEL_LSB       = 8;
  localparam int          LEVEL_MSB       = 11;
  localparam int          BIT14_FLAG_BIT  = 14;
  localparam int          BIT15_FLAG_BIT  = 15;

  // ***************************************************
  // Sub-instruction codes
  // ***************************************************
  typedef enum logic [3:0] {
    SBO_TEST_ZERO        = 4'h0,
    SBO_TEST_ONE         = 4'h1,
    SBO_TEST_COMPL       = 4'h2,
    SBO_TEST_ACCUM       = 4'h3,
    SBO_SET_ZERO         = 4'h4,
    SBO_SET_ONE          = 4'h5,
    SBO_SET_COMPL        = 4'h6,
    SBO_SET_ACCUM        = 4'h7,
    SBO_STORE_CLEAR      = 4'h8,
    SBO_STORE_INV_SET    = 4'h9,
    SBO_LOAD_ACCUM       = 4'ha,
    SBO_LOAD_ACCUM_INV   = 4'hb,
    SBO_AND_INV_ACCUM    = 4'hc,
    SBO_OR_INV_ACCUM     = 4'hd,
    SBO_AND_ACCUM        = 4'he,
    SBO_OR_ACCUM         = 4'hf
  } sbo_sub_t;

endpackage

`default_nettype wire

//--- logic/sbo_unit.sv
`timescale 1ns/1ps
`default_nettype none

module sbo_unit (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Instruction issue
  input  wire logic        i_exec,
  input  wire logic [15:0] i_instr,
  // General register file read
  output logic [2:0]       o_reg_rd_sel,
  input  wire logic [15:0] i_reg_rd_data,
  // General register file write
  output logic             o_reg_wr_en,
  output logic [2:0]       o_reg_wr_sel,
  output logic [15:0]      o_reg_wr_data,
  // Status word upper fields from the core
  input  wire logic [3:0]  i_current_program_level,
  input  wire logic        i_status_bit14_flag,
  input  wire logic        i_status_bit15_flag,
  // Status word lower byte update from the core
  input  wire logic        i_psw_wr_en,
  input  wire logic [7:0]  i_psw_wr_data,
  // Results
  output logic [15:0]      o_processor_status_word,
  output logic             o_done,
  output logic             o_skip
);

  // ***************************************************
  // Instruction decode
  // ***************************************************
  sbo_pkg::sbo_sub_t sub;
  logic [3:0]        bit_index;
  logic [2:0]        target_register_select;
  logic              use_psw;
  logic [15:0]       operand;
  logic              sel_bit;
  logic [7:0]        psw_low;
  logic              accum;

  assign sub                    = sbo_pkg::sbo_sub_t'(i_instr[sbo_pkg::SUB_MSB:sbo_pkg::SUB_LSB]);
  assign bit_index              = i_instr[sbo_pkg::BIDX_MSB:sbo_pkg::BIDX_LSB];
  assign target_register_select = i_instr[sbo_pkg::RSEL_MSB:sbo_pkg::RSEL_LSB];
  assign use_psw                = (target_register_select == sbo_pkg::PSW_SELECT);
  assign accum                  = psw_low[sbo_pkg::ACCUM_BIT];

  assign o_reg_rd_sel = target_register_select;

  // ***************************************************
  // Status word assembly
  // ***************************************************
  function automatic logic [15:0] make_psw(input logic [7:0] low,
                                           input logic [3:0] lvl,
                                           input logic       f14,
                                           input logic       f15);
    logic [15:0] w;
    w                                            = 16'h0000;
    w[7:0]                                       = low;
    w[sbo_pkg::LEVEL_MSB:sbo_pkg::LEVEL_LSB]     = lvl;
    w[sbo_pkg::BIT14_FLAG_BIT]                   = f14;
    w[sbo_pkg::BIT15_FLAG_BIT]                   = f15;
    return w;
  endfunction

  logic [15:0] psw_view;
  assign psw_view = make_psw(psw_low, i_current_program_level,
                             i_status_bit14_flag, i_status_bit15_flag);

  assign operand = use_psw ? psw_view : i_reg_rd_data;
  assign sel_bit = operand[bit_index];

  // ***************************************************
  // Operation
  // ***************************************************
  logic        next_bit;
  logic        next_accum;
  logic        bit_wr;
  logic        skip_cond;
  logic [15:0] next_word;
  logic [7:0]  next_psw_low;

  // Skip condition of the four bit tests
  function automatic logic test_skip(input sbo_pkg::sbo_sub_t s,
                                     input logic              b,
                                     input logic              k);
    logic skip;
    skip = 1'b0;
    case (s)
      sbo_pkg::SBO_TEST_ZERO: begin
        skip = ~b;
      end
      sbo_pkg::SBO_TEST_ONE: begin
        skip = b;
      end
      sbo_pkg::SBO_TEST_COMPL: begin
        skip = (~b == k);
      end
      sbo_pkg::SBO_TEST_ACCUM: begin
        skip = (b == k);
      end
      default: begin
        skip = 1'b0;
      end
    endcase
    return skip;
  endfunction

  // Set and store variants rewrite the chosen bit
  function automatic logic writes_bit(input sbo_pkg::sbo_sub_t s);
    logic wr;
    wr = 1'b0;
    case (s)
      sbo_pkg::SBO_SET_ZERO,
      sbo_pkg::SBO_SET_ONE,
      sbo_pkg::SBO_SET_COMPL,
      sbo_pkg::SBO_SET_ACCUM,
      sbo_pkg::SBO_STORE_CLEAR,
      sbo_pkg::SBO_STORE_INV_SET: begin
        wr = 1'b1;
      end
      default: begin
        wr = 1'b0;
      end
    endcase
    return wr;
  endfunction

  // Value written into the chosen bit
  function automatic logic bit_value(input sbo_pkg::sbo_sub_t s,
                                     input logic              b,
                                     input logic              k);
    logic v;
    v = b;
    case (s)
      sbo_pkg::SBO_SET_ZERO: begin
        v = 1'b0;
      end
      sbo_pkg::SBO_SET_ONE: begin
        v = 1'b1;
      end
      sbo_pkg::SBO_SET_COMPL: begin
        v = ~b;
      end
      sbo_pkg::SBO_SET_ACCUM: begin
        v = k;
      end
      sbo_pkg::SBO_STORE_CLEAR: begin
        v = k;
      end
      sbo_pkg::SBO_STORE_INV_SET: begin
        v = ~k;
      end
      default: begin
        v = b;
      end
    endcase
    return v;
  endfunction

  // New value of the one-bit accumulator
  function automatic logic accum_value(input sbo_pkg::sbo_sub_t s,
                                       input logic              b,
                                       input logic              k);
    logic a;
    a = k;
    case (s)
      sbo_pkg::SBO_STORE_CLEAR: begin
        a = 1'b0;
      end
      sbo_pkg::SBO_STORE_INV_SET: begin
        a = 1'b1;
      end
      sbo_pkg::SBO_LOAD_ACCUM: begin
        a = b;
      end
      sbo_pkg::SBO_LOAD_ACCUM_INV: begin
        a = ~b;
      end
      sbo_pkg::SBO_AND_INV_ACCUM: begin
        a = ~b & k;
      end
      sbo_pkg::SBO_OR_INV_ACCUM: begin
        a = ~b | k;
      end
      sbo_pkg::SBO_AND_ACCUM: begin
        a = b & k;
      end
      sbo_pkg::SBO_OR_ACCUM: begin
        a = b | k;
      end
      default: begin
        a = k;
      end
    endcase
    return a;
  endfunction

  // Word with one bit replaced, the rest kept
  function automatic logic [15:0] put_bit(input logic [15:0] word,
                                          input logic [3:0]  idx,
                                          input logic        val);
    logic [15:0] w;
    w      = word;
    w[idx] = val;
    return w;
  endfunction

  assign skip_cond  = test_skip(sub, sel_bit, accum);
  assign bit_wr     = writes_bit(sub);
  assign next_bit   = bit_value(sub, sel_bit, accum);
  assign next_accum = accum_value(sub, sel_bit, accum);
  assign next_word  = put_bit(operand, bit_index, next_bit);

  // ***************************************************
  // Status word low byte and accumulator
  // ***************************************************
  always_comb begin
    next_psw_low = psw_low;
    if (i_exec) begin
      if (bit_wr && use_psw) begin
        // Only the low byte is writable
        next_psw_low = next_word[7:0] & sbo_pkg::PSW_WRITE_MASK[7:0];
        // A bit write on the accumulator position wins
        if (bit_index != 4'(sbo_pkg::ACCUM_BIT)) begin
          next_psw_low[sbo_pkg::ACCUM_BIT] = next_accum;
        end
      end else begin
        next_psw_low[sbo_pkg::ACCUM_BIT] = next_accum;
      end
    end else if (i_psw_wr_en) begin
      // Core update only when no bit operation runs
      next_psw_low = i_psw_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      psw_low <= sbo_pkg::PSW_RESET[7:0];
    end else begin
      psw_low <= next_psw_low;
    end
  end

  // ***************************************************
  // Register write-back and results
  // ***************************************************
  // Strobe only for a set or store on a general register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_wr_en <= 1'b0;
    end else begin
      o_reg_wr_en <= i_exec && bit_wr && !use_psw;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_wr_sel <= 3'h0;
    end else begin
      o_reg_wr_sel <= target_register_select;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_wr_data <= 16'h0000;
    end else begin
      o_reg_wr_data <= next_word;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= i_exec;
    end
  end

  // Skip pulses only for a test whose condition holds
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_skip <= 1'b0;
    end else begin
      o_skip <= i_exec && skip_cond;
    end
  end

  assign o_processor_status_word = psw_view;

endmodule

`default_nettype wire

//--- testbench/sbo_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbo_regfile_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Register file ports
  input  wire logic [2:0]  i_rd_sel,
  output logic [15:0]      o_rd_data,
  input  wire logic        i_wr_en,
  input  wire logic [2:0]  i_wr_sel,
  input  wire logic [15:0] i_wr_data
);
  logic [15:0] mem [8];
  logic [15:0] junk = 16'h5a5a;
  initial for (int i = 0; i < 8; i++) mem[i] = 16'h1357 * i[15:0];
  // Select zero is no register: a moving pattern
  assign o_rd_data = (i_rd_sel == 3'h0) ? junk : mem[i_rd_sel];
  always @(posedge i_clk_sys) begin
    junk <= ~junk;
    if (i_wr_en && i_wr_sel != 3'h0) mem[i_wr_sel] <= i_wr_data;
  end
endmodule
`default_nettype wire

//--- testbench/sbo_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbo_unit_sva (
  // Watched ports
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_exec,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_reg_rd_data,
  input wire logic [3:0]  i_current_program_level,
  input wire logic        i_status_bit14_flag,
  input wire logic        i_status_bit15_flag,
  input wire logic        o_reg_wr_en,
  input wire logic [15:0] o_reg_wr_data,
  input wire logic [15:0] o_processor_status_word,
  input wire logic        o_done,
  input wire logic        o_skip
);
  wire logic [3:0] sub = i_instr[10:7];
  wire logic [3:0] idx = i_instr[6:3];
  wire logic sel = (i_instr[2:0] == 3'h0) ? o_processor_status_word[idx] : i_reg_rd_data[idx];
  wire logic k = o_processor_status_word[2];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence issue(logic [3:0] c);
    i_exec && sub == c;
  endsequence
  chk_done_once: assert property (1'h1 |=> o_done == $past(i_exec))
    else $error("done not one cycle after exec");
  chk_skip_zero: assert property (issue(4'h0) |=> o_skip == !$past(sel))
    else $error("zero test skip wrong");
  chk_skip_one: assert property (issue(4'h1) |=> o_skip == $past(sel))
    else $error("one test skip wrong");
  chk_skip_inv_k: assert property (issue(4'h2) |=> o_skip == ($past(sel) != $past(k)))
    else $error("inverse accum test skip wrong");
  chk_skip_eq_k: assert property (issue(4'h3) |=> o_skip == ($past(sel) == $past(k)))
    else $error("accum test skip wrong");
  chk_skip_quiet: assert property (i_exec && sub[3:2] != 2'h0 |=> !o_skip)
    else $error("skip from non test op");
  chk_test_nowrite: assert property (i_exec && sub[3:2] == 2'h0 |=>
    !o_reg_wr_en && $stable(o_processor_status_word[7:0]))
    else $error("test op changed state");
  chk_wr_one_bit: assert property (o_reg_wr_en |->
    ((o_reg_wr_data ^ $past(i_reg_rd_data)) & ~(16'h1 << $past(idx))) == 16'h0)
    else $error("write touched other bits");
  chk_set_one: assert property (issue(4'h5) && i_instr[2:0] != 3'h0 |=>
    o_reg_wr_en && o_reg_wr_data[$past(idx)])
    else $error("set one not written");
  chk_status_ro: assert property (o_processor_status_word[15:8] == {i_status_bit15_flag,
    i_status_bit14_flag, 2'h0, i_current_program_level})
    else $error("status upper fields wrong");
endmodule
bind sbo_unit sbo_unit_sva u_sva (.i_clk_sys, .i_nrst, .i_exec, .i_instr, .i_reg_rd_data,
  .i_current_program_level, .i_status_bit14_flag, .i_status_bit15_flag, .o_reg_wr_en,
  .o_reg_wr_data, .o_processor_status_word, .o_done, .o_skip);
`default_nettype wire

//--- testbench/tb_single_bit_operation_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_single_bit_operation_unit;
  logic i_clk_sys = 0, i_nrst = 0, i_exec = 0, i_psw_wr_en = 0, f14 = 0, f15 = 0;
  logic we, done, skip;
  logic [15:0] i_instr = 16'h0, rd, wd, psw, v;
  logic [2:0] rsel, wsel;
  logic [3:0] lvl = 4'h0;
  logic [7:0] pdata = 8'h0, lo = 8'h0;
  logic [15:0] m [8];
  int errors = 0, checked = 0, seed = 32'hd8b0ee01;
  always #2.5 i_clk_sys = ~i_clk_sys;
  sbo_unit dut_u (.i_clk_sys, .i_nrst, .i_exec, .i_instr, .o_reg_rd_sel(rsel),
    .i_reg_rd_data(rd), .o_reg_wr_en(we), .o_reg_wr_sel(wsel), .o_reg_wr_data(wd),
    .i_current_program_level(lvl), .i_status_bit14_flag(f14), .i_status_bit15_flag(f15),
    .i_psw_wr_en, .i_psw_wr_data(pdata), .o_processor_status_word(psw), .o_done(done),
    .o_skip(skip));
  sbo_regfile_model pm (.i_clk_sys, .i_rd_sel(rsel), .o_rd_data(rd), .i_wr_en(we),
    .i_wr_sel(wsel), .i_wr_data(wd));
  initial for (int i = 0; i < 8; i++) m[i] = 16'h1357 * i[15:0];
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Returns skip, new bit, new accumulator
  function automatic logic [2:0] f(logic [3:0] s, logic b, logic k);
    case (s)
      4'h0: f = {!b, b, k};
      4'h1: f = {b, b, k};
      4'h2: f = {!b == k, b, k};
      4'h3: f = {b == k, b, k};
      4'h4: f = {2'h0, k};
      4'h5: f = {2'h1, k};
      4'h6: f = {1'h0, !b, k};
      4'h7: f = {1'h0, k, k};
      4'h8: f = {1'h0, k, 1'h0};
      4'h9: f = {1'h0, !k, 1'h1};
      4'ha: f = {1'h0, b, b};
      4'hb: f = {1'h0, b, !b};
      4'hc: f = {1'h0, b, !b & k};
      4'hd: f = {1'h0, b, !b | k};
      4'he: f = {1'h0, b, b & k};
      default: f = {1'h0, b, b | k};
    endcase
  endfunction
  task run(input logic [15:0] ins);
    logic [3:0] s, ix;
    logic [2:0] rs, r;
    logic wr;
    logic [15:0] pv;
    s = ins[10:7];
    ix = ins[6:3];
    rs = ins[2:0];
    pv = {f15, f14, 2'h0, lvl, lo};
    r = f(s, (rs == 3'h0) ? pv[ix] : m[rs][ix], lo[2]);
    wr = s[3:2] == 2'h1 || s[3:1] == 3'h4;
    @(posedge i_clk_sys);
    i_instr <= ins;
    i_exec <= 1'h1;
    i_psw_wr_en <= 1'($random(seed));
    pdata <= 8'($random(seed));
    @(posedge i_clk_sys);
    i_exec <= 1'h0;
    i_psw_wr_en <= 1'h0;
    #1 chk("done", {15'h0, done}, 16'h1);
    chk("skip", {15'h0, skip}, {15'h0, r[2]});
    chk("wr_en", {15'h0, we}, {15'h0, wr && rs != 3'h0});
    chk("rd_sel", {13'h0, rsel}, {13'h0, rs});
    chk("wr_sel", {13'h0, wsel}, {13'h0, rs});
    lo[2] = r[0];
    if (wr && rs != 3'h0) m[rs][ix] = r[1];
    else if (wr && !ix[3]) lo[ix[2:0]] = r[1];
    chk("psw", psw, {f15, f14, 2'h0, lvl, lo});
    @(posedge i_clk_sys);
    #1 chk("reg", pm.mem[rs], m[rs]);
  endtask
  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #50000 errors++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    #1 chk("reset", psw, 16'h0);
    for (int i = 0; i < 48; i++) run({5'h0, 4'(i), (i < 16) ? 4'h2 : 4'hf, (i < 32) ? 3'h0 : 3'h7});
    @(posedge i_clk_sys);
    {i_exec, i_instr} <= {1'h1, 16'h0280};
    @(posedge i_clk_sys);
    {i_exec, i_nrst} <= {1'h0, 1'h0};
    #1 chk("reset_psw", psw, {f15, f14, 2'h0, lvl, 8'h0});
    chk("reset_done", {15'h0, done}, 16'h0);
    lo = 8'h0;
    @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    $display("corner tests done");
    for (int i = 0; i < 300; i++) begin
      if (i % 8 == 0) begin
        v = 16'($random(seed));
        @(posedge i_clk_sys);
        {i_psw_wr_en, pdata, lvl, f14, f15} <= {1'h1, v[7:0], v[11:8], v[14], v[15]};
        @(posedge i_clk_sys);
        i_psw_wr_en <= 1'h0;
        lo = v[7:0];
      end
      v = 16'($random(seed));
      if (i % 4 == 0) v[2:0] = 3'h0;
      run(v);
    end
    $display("random tests done");
    end_sim;
  end
endmodule
`default_nettype wire
